// ---- core/sad_decoder.sv ----
// First-level address decoder with boot remap and SRAM partitioning.
// Assumes masters present one address phase per cycle on clk; outputs are
// selects that the bus matrix uses in the same cycle.
`timescale 1ns/1ps
`include "sad_map.svh"
module sad_decoder (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Address phase from the bus side.
   input wire sad_pkg::sad_req_t req,
   // Coupled-memory access strobe from the processor side.
   input wire logic tcm_access,
   // Configuration and control.
   input wire logic boot_source_select,
   input wire logic remap_command,
   input wire sad_pkg::sad_split_t split_select,
   input wire logic tcm_wait_state_enable,
   input wire logic [31:0] chip_select_assign_reg,
   // Routing answer.
   output sad_pkg::sad_route_t route,
   output logic [5:0] ext_chip_select_n,
   output logic ddr_chip_select_n,
   output logic periph_bridge_sel,
   output logic error_response,
   // Coupled-memory answer and status.
   output logic tcm_wait,
   output logic remapped,
   output logic external_bus_drive_select,
   output logic ddr_drive_select
);
   import sad_pkg::*;

   logic boot_sync_a;
   logic boot_sync;
   logic remap_flag;
   logic tcm_wait_q;
   logic [31:0] a;
   logic [3:0] bank;
   logic [31:0] instr_cm_size;
   logic [31:0] data_cm_size;
   logic [31:0] gen_size;
   sad_route_t next_route;

   // True when addr lies in [base, base+size); a zero size never matches.
   function automatic logic in_window(input logic [31:0] addr,
         input logic [31:0] base, input logic [31:0] size);
      in_window = (size != 32'h0) && (addr >= base) &&
         ((addr - base) < size);
   endfunction

   // Boot select is a pin; two flops before anything reads it.
   always_ff @(posedge clk) begin
      boot_sync_a <= boot_source_select;
      boot_sync <= boot_sync_a;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         remap_flag <= 1'b0;
      end else if (remap_command) begin
         remap_flag <= 1'b1;
      end
   end

   always_comb begin
      instr_cm_size = 32'h0;
      data_cm_size = 32'h0;
      gen_size = 32'h0;
      case (split_select)
         SAD_SPLIT_GENERAL: gen_size = `SAD_FULL_SIZE;
         SAD_SPLIT_DATA: data_cm_size = `SAD_FULL_SIZE;
         SAD_SPLIT_HALVES: begin
            instr_cm_size = `SAD_HALF_SIZE;
            data_cm_size = `SAD_HALF_SIZE;
         end
         default: gen_size = 32'h0;
      endcase
   end

   assign a = req.addr;
   assign bank = a[31:28];

   always_comb begin
      next_route = '0;
      next_route.target = SAD_TGT_ABORT;
      if (!req.valid) begin
         next_route.target = SAD_TGT_NONE;
      end else if (bank >= `SAD_BANK_EXT_FIRST &&
            bank <= `SAD_BANK_EXT_LAST) begin
         next_route.target = SAD_TGT_EXT;
         next_route.ext_sel = 6'h01 << (bank - `SAD_BANK_EXT_FIRST);
      end else if (bank == `SAD_BANK_DDR) begin
         next_route.target = SAD_TGT_DDR;
         next_route.ddr_sel = 1'b1;
      end else if (bank == `SAD_BANK_INTERNAL) begin
         if (in_window(a, `SAD_ZERO_BASE, `SAD_ROM_SIZE) && !remap_flag &&
               boot_sync) begin
            next_route.target = SAD_TGT_ROM;
            next_route.rom_offset = a[15:0];
         end else if (in_window(a, `SAD_ZERO_BASE, gen_size) &&
               remap_flag && req.cpu_master) begin
            next_route.target = SAD_TGT_SRAM;
            next_route.sram_offset = a[15:0];
         end else if (in_window(a, `SAD_ROM_BASE, `SAD_ROM_SIZE)) begin
            next_route.target = SAD_TGT_ROM;
            next_route.rom_offset = a[15:0];
         // coupled regions reachable from the bus
         end else if (in_window(a, `SAD_INSTR_CM_BASE, instr_cm_size)) begin
            next_route.target = SAD_TGT_SRAM;
            next_route.sram_offset = a[15:0];
         end else if (in_window(a, `SAD_DATA_CM_BASE, data_cm_size)) begin
            next_route.target = SAD_TGT_SRAM;
            next_route.sram_offset = 16'(a[15:0] + instr_cm_size[15:0]);
         // general SRAM through one slave port
         end else if (in_window(a, `SAD_SRAM_BASE, gen_size)) begin
            next_route.target = SAD_TGT_SRAM;
            next_route.sram_offset = a[15:0];
         end
      end else if (bank == `SAD_BANK_PERIPH) begin
         if (a >= `SAD_SYSC_LO) begin
            next_route.target = SAD_TGT_SYSC;
         end else if (a >= `SAD_USER_LO && a <= `SAD_USER_HI) begin
            next_route.target = SAD_TGT_USER;
            next_route.user_slot = 6'((a - `SAD_USER_LO) >> `SAD_SLOT_SHIFT);
         end
      end
      next_route.abort = (next_route.target == SAD_TGT_ABORT);
   end

   assign route = next_route;
   assign ext_chip_select_n = ~next_route.ext_sel;
   assign ddr_chip_select_n = ~next_route.ddr_sel;
   assign periph_bridge_sel = (next_route.target == SAD_TGT_SYSC) ||
      (next_route.target == SAD_TGT_USER);
   assign error_response = next_route.abort;
   assign remapped = remap_flag;

   // one wait state per coupled access
   // processor-side path with its own wait control
   always_ff @(posedge clk) begin
      if (rst) begin
         tcm_wait_q <= 1'b0;
      end else begin
         tcm_wait_q <= tcm_access && tcm_wait_state_enable && !tcm_wait_q;
      end
   end
   assign tcm_wait = tcm_access && tcm_wait_state_enable && !tcm_wait_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         external_bus_drive_select <= 1'b0;
         ddr_drive_select <= 1'b0;
      end else begin
         external_bus_drive_select <=
            chip_select_assign_reg[`SAD_EXT_DRIVE_BIT];
         ddr_drive_select <= chip_select_assign_reg[`SAD_DDR_DRIVE_BIT];
      end
   end

   // Assertions.
   a_ext_select: assert property (
      @(posedge clk) disable iff (rst)
      req.valid && bank == `SAD_BANK_EXT_FIRST |->
      ext_chip_select_n == 6'h3E)
      else $error("bank one did not select chip select zero");
   a_ddr_select: assert property (
      @(posedge clk) disable iff (rst)
      req.valid && bank == `SAD_BANK_DDR |->
      !ddr_chip_select_n && !error_response)
      else $error("bank seven did not select DDR");
   a_unused_abort: assert property (
      @(posedge clk) disable iff (rst)
      req.valid && bank > `SAD_BANK_DDR && bank < `SAD_BANK_PERIPH |->
      error_response)
      else $error("unused bank not aborted");
   a_periph_bridge: assert property (
      @(posedge clk) disable iff (rst)
      req.valid && a >= `SAD_SYSC_LO |-> periph_bridge_sel)
      else $error("system controller access not bridged");
   a_remap_sticky: assert property (
      @(posedge clk) disable iff (rst)
      remap_flag |=> remap_flag)
      else $error("remap flag dropped");
   a_remap_set: assert property (
      @(posedge clk) disable iff (rst)
      remap_command |=> remap_flag)
      else $error("remap command not taken");
   a_tcm_wait_one: assert property (
      @(posedge clk) disable iff (rst)
      tcm_access && tcm_wait_state_enable && !tcm_wait_q
      |=> tcm_wait_q)
      else $error("wait state not counted");
   a_no_wait_off: assert property (
      @(posedge clk) disable iff (rst)
      !tcm_wait_state_enable |-> !tcm_wait)
      else $error("wait inserted while disabled");
   a_rom_always: assert property (
      @(posedge clk) disable iff (rst)
      req.valid && a == `SAD_ROM_BASE |-> route.target == SAD_TGT_ROM)
      else $error("ROM not at its fixed base");
   a_drive_follow: assert property (
      @(posedge clk) disable iff (rst)
      1'b1 |=> external_bus_drive_select ==
      $past(chip_select_assign_reg[`SAD_EXT_DRIVE_BIT]))
      else $error("drive bit not followed");
   a_ddr_drive: assert property (
      @(posedge clk) disable iff (rst)
      1'b1 |=> ddr_drive_select ==
      $past(chip_select_assign_reg[`SAD_DDR_DRIVE_BIT]))
      else $error("DDR drive bit not followed");
   c_remap: cover property (@(posedge clk) remap_command && !remap_flag);
   c_abort: cover property (@(posedge clk) error_response);
   c_tcm: cover property (@(posedge clk) tcm_wait);
   c_user: cover property (@(posedge clk) route.target == SAD_TGT_USER);
endmodule

// ---- inc/sad_map.svh ----
// Address map constants for the system address decoder with boot remap.
// Assumes 32-bit byte addresses and a single system bus clock.
//
// Notes on behaviour
// - Sixteen 256 MB banks chosen by the top four address bits.
// - Banks one to six go to external chip selects zero to five.
// - Bank seven goes to the DDR controller with its chip select.
// - Bank zero holds internal memories, second decode over 1 MB.
// - Bank fifteen forwards through the bridge to the peripheral bus.
// - Accesses to unassigned banks or regions get an error response.
// - Internal SRAM is 64 KB, four 16 KB blocks, one slave port.
// - SRAM at 0x00300000 before remap; also at zero for CPU master accesses after remap, in the 0/0/64 split only.
// - SRAM has a coupled-port path and a system bus path.
// - Wait-state bit adds one wait on instruction and data TCM accesses.
// - Coupled SRAM regions stay reachable from bus masters.
// - Split settings 0/0/64, 0/64/0, 32/32/0 at 1, 2, 3 MB.
// - ROM always at 0x00400000; at zero before remap if boot select set.
// - Bits 17 and 18 pick external bus and DDR drive strength.
// - System controller registers decode in 0xFFFFE800 to 0xFFFFFFFF.
// - User peripherals use 16 KB slots from 0xFFF78000 to 0xFFFCFFFF.
`ifndef SAD_MAP_SVH
`define SAD_MAP_SVH
`define SAD_BANK_INTERNAL 4'h0
`define SAD_BANK_EXT_FIRST 4'h1
`define SAD_BANK_EXT_LAST 4'h6
`define SAD_BANK_DDR 4'h7
`define SAD_BANK_PERIPH 4'hF
`define SAD_INT_REGION_MASK 32'h0FF00000
`define SAD_INSTR_CM_BASE 32'h00100000
`define SAD_DATA_CM_BASE 32'h00200000
`define SAD_SRAM_BASE 32'h00300000
`define SAD_ROM_BASE 32'h00400000
`define SAD_ZERO_BASE 32'h00000000
`define SAD_SRAM_OFS_W 16
`define SAD_HALF_SIZE 32'h00008000
`define SAD_FULL_SIZE 32'h00010000
`define SAD_MB_MASK 32'hFFF00000
`define SAD_ROM_SIZE 32'h00010000
`define SAD_SYSC_LO 32'hFFFFE800
`define SAD_USER_LO 32'hFFF78000
`define SAD_USER_HI 32'hFFFCFFFF
`define SAD_SLOT_SHIFT 14
`define SAD_EXT_DRIVE_BIT 17
`define SAD_DDR_DRIVE_BIT 18
`endif

// ---- inc/sad_pkg.sv ----
// Types shared by the system address decoder.
// Assumes the map header defines all numeric constants.
package sad_pkg;
   typedef enum logic [1:0] {
      SAD_SPLIT_GENERAL,
      SAD_SPLIT_DATA,
      SAD_SPLIT_HALVES,
      SAD_SPLIT_BAD
   } sad_split_t;
   typedef enum logic [3:0] {
      SAD_TGT_NONE,
      SAD_TGT_EXT,
      SAD_TGT_DDR,
      SAD_TGT_SRAM,
      SAD_TGT_ROM,
      SAD_TGT_SYSC,
      SAD_TGT_USER,
      SAD_TGT_ABORT
   } sad_target_t;
   // One address-phase request from a bus master.
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic cpu_master;
   } sad_req_t;
   // Slave selects derived from one request.
   typedef struct packed {
      sad_target_t target;
      logic [5:0] ext_sel;
      logic ddr_sel;
      logic [15:0] sram_offset;
      logic [15:0] rom_offset;
      logic [5:0] user_slot;
      logic abort;
   } sad_route_t;
endpackage

// ---- sim/sad_slave_model.sv ----
// Far-side slaves of the decoder, reduced to a count of responders.
// Assumes the decoder's selects are settled when the count is read.
`timescale 1ns/1ps
module sad_slave_model (
   // Selects from the decoder.
   input wire sad_pkg::sad_route_t route,
   input wire logic [5:0] ext_chip_select_n,
   input wire logic ddr_chip_select_n,
   input wire logic periph_bridge_sel,
   input wire logic error_response,
   // How many slaves claim the access.
   output logic [3:0] responders
);
   import sad_pkg::*;
   // abort answers alone
   // Each slave answers only its own select, so a count above one is a clash.
   always_comb begin
      responders = {3'h0, ~ddr_chip_select_n} + {3'h0, periph_bridge_sel};
      responders += {3'h0, error_response};
      responders += {3'h0, route.target inside {SAD_TGT_SRAM, SAD_TGT_ROM}};
      for (int i = 0; i < 6; i++) begin
         responders += {3'h0, ~ext_chip_select_n[i]};
      end
   end
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the address decoder with boot remap.
// Assumes one 20 MHz clock and inputs changed 2 ns after each edge.
`timescale 1ns/1ps
module testbench;
   import sad_pkg::*;
   logic clk, rst, tcm_access, boot_source_select, remap_command;
   logic tcm_wait_state_enable, ddr_chip_select_n, periph_bridge_sel;
   logic error_response, tcm_wait, remapped;
   logic external_bus_drive_select, ddr_drive_select;
   logic [31:0] chip_select_assign_reg;
   logic [5:0] ext_chip_select_n;
   logic [3:0] responders;
   sad_req_t req;
   sad_split_t split_select;
   sad_route_t route;
   int n_errors, comparisons;
   sad_decoder sad_decoder_inst (.clk(clk), .rst(rst), .req(req),
      .tcm_access(tcm_access), .boot_source_select(boot_source_select),
      .remap_command(remap_command), .split_select(split_select),
      .tcm_wait_state_enable(tcm_wait_state_enable),
      .chip_select_assign_reg(chip_select_assign_reg), .route(route),
      .ext_chip_select_n(ext_chip_select_n),
      .ddr_chip_select_n(ddr_chip_select_n),
      .periph_bridge_sel(periph_bridge_sel),
      .error_response(error_response), .tcm_wait(tcm_wait),
      .remapped(remapped),
      .external_bus_drive_select(external_bus_drive_select),
      .ddr_drive_select(ddr_drive_select));
   sad_slave_model sad_slave_model_inst (.route(route),
      .ext_chip_select_n(ext_chip_select_n),
      .ddr_chip_select_n(ddr_chip_select_n),
      .periph_bridge_sel(periph_bridge_sel),
      .error_response(error_response), .responders(responders));
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Waits an edge, then steps 2 ns on; every change lands there.
   task automatic step();
      @(posedge clk);
      #2;
   endtask
   // One address phase; decode is combinational, so read 1 ns later.
   task automatic acc(logic [31:0] a, logic v, logic cpu = 1'b1);
      step();
      req = '{valid: v, addr: a, cpu_master: cpu};
      #1;
      chk("responders", responders, {31'h0, v});
   endtask
   task automatic t_banks();
      for (int b = 1; b < 16; b++) begin
         acc({4'(b), 28'h0000040}, 1'b1);
         chk("ext_cs", ext_chip_select_n,
            b < 7 ? ~(1 << b - 1) & 63 : 63);
         chk("ddr_cs", ddr_chip_select_n, b != 7);
         chk("abort", error_response, b > 7);
         chk("abort_f", route.abort, b > 7);
      end
      acc(32'h10000000, 1'b0);
      chk("idle", route.target, SAD_TGT_NONE);
      $display("test banks done");
   endtask
   task automatic t_periph();
      acc(32'hFFFFE800, 1'b1);
      chk("sysc", periph_bridge_sel, 1);
      acc(32'hFFFCC000, 1'b1);
      chk("user", periph_bridge_sel, 1);
      chk("slot", route.user_slot, 32'h15);
      acc(32'hFFF74000, 1'b1);
      chk("hole", error_response, 1);
      $display("test periph done");
   endtask
   // Table of split, address, target and offset, walked in order.
   // The last row uses the split code that maps no SRAM at all.
   task automatic t_sram();
      logic [1:0] sp [10] = '{0, 0, 1, 1, 2, 2, 2, 0, 0, 3};
      logic [31:0] ad [10] = '{32'h0030FFFC, 32'h00100000, 32'h0020FFFC,
         32'h00300000, 32'h00107FFC, 32'h00200004, 32'h00208000,
         32'h00400010, 32'h00500000, 32'h00300000};
      sad_target_t tg [10] = '{SAD_TGT_SRAM, SAD_TGT_ABORT, SAD_TGT_SRAM,
         SAD_TGT_ABORT, SAD_TGT_SRAM, SAD_TGT_SRAM, SAD_TGT_ABORT,
         SAD_TGT_ROM, SAD_TGT_ABORT, SAD_TGT_ABORT};
      logic [15:0] of [10] = '{16'hFFFC, 0, 16'hFFFC, 0, 16'h7FFC, 16'h8004,
         0, 16'h0010, 0, 0};
      for (int i = 0; i < 10; i++) begin
         step();
         split_select = sad_split_t'(sp[i]);
         acc(ad[i], 1'b1);
         chk("target", route.target, tg[i]);
         if (tg[i] == SAD_TGT_SRAM) begin
            chk("ofs", route.sram_offset, of[i]);
         end
         if (tg[i] == SAD_TGT_ROM) begin
            chk("rom", route.rom_offset, of[i]);
         end
      end
      split_select = SAD_SPLIT_GENERAL;
      $display("test sram done");
   endtask
   task automatic t_remap();
      acc(32'h00000010, 1'b1);
      chk("no_boot", error_response, 1);
      step();
      boot_source_select = 1'b1;
      repeat (3) step();
      for (int k = 0; k < 2; k++) begin
         acc(32'h00000010, 1'b1);
         chk("boot_rom", route.target, SAD_TGT_ROM);
         chk("flag0", remapped, 0);
         step();
         remap_command = 1'b1;
         step();
         remap_command = 1'b0;
         acc(32'h00000010, 1'b1);
         chk("flag1", remapped, 1);
         chk("alias", route.target, SAD_TGT_SRAM);
         chk("alias_ofs", route.sram_offset, 32'h10);
         acc(32'h00000010, 1'b1, 1'b0);
         chk("dma_alias", error_response, 1);
         step();
         rst = 1'b1;
         step();
         rst = 1'b0;
      end
      $display("test remap done");
   endtask
   // Held coupled access: wait alternates only while enabled.
   task automatic t_tcm_drive();
      tcm_access = 1'b1;
      for (int c = 0; c < 5; c++) begin
         tcm_wait_state_enable = c < 3;
         chip_select_assign_reg = 32'h00020000 << c % 2;
         #1;
         chk("tcm_wait", tcm_wait, c % 2 == 0 && c < 3);
         step();
         chk("ext_drv", external_bus_drive_select, c % 2 == 0);
         chk("ddr_drv", ddr_drive_select, c % 2);
      end
      $display("test tcm drive done");
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Boot pin is cleared from time zero, since its sync flops have no reset.
   initial begin
      {rst, req, tcm_access, boot_source_select, remap_command} = '0;
      {tcm_wait_state_enable, chip_select_assign_reg} = '0;
      split_select = SAD_SPLIT_GENERAL;
      rst = 1'b1;
      repeat (20) step();
      rst = 1'b0;
      t_banks();
      t_periph();
      t_sram();
      t_remap();
      t_tcm_drive();
      tally_and_finish();
   end
   // The tests need under 200 cycles; 2000 means a hang.
   initial begin
      #100000;
      n_errors++;
      tally_and_finish();
   end
endmodule
